// ---- verilog/rst_irq_pkg.sv ----
// Package for the reset-state and interrupt-source block.
// Assumes a 200 MHz hclk and word-aligned AHB-Lite register access.
`default_nettype none
package rst_irq_pkg;
  // Register byte offsets.
  localparam logic [31:0] OFF_IRQ_ENABLE = 32'h0000_0000;
  localparam logic [31:0] OFF_IRQ_LEVEL = 32'h0000_0004;
  localparam logic [31:0] OFF_TMR2_MODE = 32'h0000_0008;
  localparam logic [31:0] OFF_TMR_CONTROL = 32'h0000_000C;
  localparam logic [31:0] OFF_DOG_CONTROL = 32'h0000_0010;
  localparam logic [31:0] OFF_EXT_IRQ_ENABLE = 32'h0000_0014;
  localparam logic [31:0] OFF_UART0_CONTROL = 32'h0000_0018;
  localparam logic [31:0] OFF_EXT_IRQ_LEVEL = 32'h0000_001C;
  localparam logic [31:0] OFF_UART1_CONTROL = 32'h0000_0020;
  localparam logic [31:0] OFF_EXT_IRQ_FLAG = 32'h0000_0024;
  localparam logic [31:0] OFF_TMR2_STATUS = 32'h0000_0028;
  localparam logic [31:0] OFF_STACK_POINTER = 32'h0000_002C;
  localparam logic [31:0] OFF_PROG_COUNTER = 32'h0000_0030;
  localparam logic [31:0] OFF_PORT_BASE = 32'h0000_0040;
  localparam logic [21:0] RAM_BASE_TAG = 22'h00_0001;
  // Field positions.
  localparam int EN_EXT0 = 0;
  localparam int EN_TMR0 = 1;
  localparam int EN_EXT1 = 2;
  localparam int EN_TMR1 = 3;
  localparam int EN_UART0 = 4;
  localparam int EN_TMR2 = 5;
  localparam int EN_UART1 = 6;
  localparam int EN_GLOBAL = 7;
  localparam int EN_DOG = 4;
  localparam int TC_SENSE0 = 0;
  localparam int TC_FLAG0 = 1;
  localparam int TC_SENSE1 = 2;
  localparam int TC_FLAG1 = 3;
  localparam int TC_OVF0 = 5;
  localparam int TC_OVF1 = 7;
  localparam int XF_FLAG2 = 4;
  localparam int T2_OVF = 7;
  localparam int T2_CAP = 6;
  localparam int DG_POWER_ON = 6;
  localparam int DG_PF_ENABLE = 5;
  localparam int DG_POWER_FAIL = 4;
  localparam int DG_EXPIRY = 3;
  localparam int DG_RESET_FLAG = 2;
  localparam int DG_RESET_EN = 1;
  localparam int UC_RX_DONE = 0;
  localparam int UC_TX_DONE = 1;
  // Reset values and masks.
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [15:0] RST_PROG_COUNTER = 16'h0000;
  localparam logic [7:0] RST_DOG_POWER_ON = 8'h40;
  localparam logic [7:0] DOG_KEEP_MASK = 8'h56;
  localparam logic [7:0] DOG_DOG_RESET_FLAG_SET = 8'h04;
  localparam logic [7:0] LEVEL_MASK = 8'h7F;
  localparam logic [7:0] EXT_MASK = 8'h1F;
  // Timing.
  localparam int CLK_MHZ = 200;
  localparam int MC_CLOCKS = 4;
  localparam logic [1:0] MC_LAST = 2'(MC_CLOCKS - 1);
  localparam logic [1:0] RST_HOLD_MC = 2'h2;
  // Interrupt source numbers, highest priority first.
  localparam int NUM_SRC = 12;
  localparam logic [3:0] SRC_EXT0 = 4'h0;
  localparam logic [3:0] SRC_TMR0 = 4'h1;
  localparam logic [3:0] SRC_EXT1 = 4'h2;
  localparam logic [3:0] SRC_TMR1 = 4'h3;
  localparam logic [3:0] SRC_EXT2 = 4'h7;
  localparam int NUM_PINS = 6;
  localparam int NUM_PORTS = 4;

  typedef struct packed {
    logic tmr0_ovf;
    logic tmr1_ovf;
    logic tmr2_ovf;
    logic tmr2_cap;
    logic rx0_done;
    logic tx0_done;
    logic rx1_done;
    logic tx1_done;
    logic dog_expiry;
    logic power_fail;
  } periph_evt_s;

  typedef struct packed {
    logic valid;
    logic [3:0] src;
  } irq_ack_s;

  typedef struct packed {
    logic counter_wr;
    logic [15:0] counter_wdata;
    logic stack_wr;
    logic [7:0] stack_wdata;
  } core_wr_s;
endpackage : rst_irq_pkg
`default_nettype wire

// ---- verilog/data_ram.sv ----
// Small on-chip data memory, 256 bytes, with a registered read port.
// Assumes one clock; it has no reset so its contents survive any reset.
`default_nettype none
module data_ram (
  // Clock.
  input wire logic clk,
  // Write port.
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port.
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [256];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : data_ram
`default_nettype wire

// ---- verilog/rst_irq_ctrl.sv ----
// Reset state and interrupt source flags, with an AHB-Lite register slave.
// Assumes pins and event strobes are synchronous to hclk, events are
// one-cycle pulses, and the core acknowledges a source on vector entry.
//
// Notes on behaviour
// - Counter held at zero; stack loads 07h.
// - Reset leaves data memory contents untouched.
// - Port output registers reset to all ones.
// - Any reset disables interrupts and timers.
// - Watchdog control reset value depends on source.
// - Power-on flag set only by power-on.
// - Power-fail flag set by event, power-on clears.
// - Watchdog reset flag set by timeout reset.
// - Watchdog reset enable cleared only by power-on.
// - Sense bit picks edge or level sampling.
// - Edge flags 0,1 cleared on service entry.
// - Level flags not cleared on service entry.
// - Pins 2-5 falling edge, software clears.
// - Acknowledge select lets hardware clear flag.
// - Timer 0/1 overflow flags cleared on service.
// - Timer 2 request is overflow OR capture.
// - Watchdog timeout flag; interrupt needs its enable.
// - Serial done flags request, never auto-cleared.
// - Software may write flags to request interrupts.
// - Per-source enables; global gate spares power-fail.
//
// The address map and the AHB-Lite interface to the registers were left to the implementer.
`default_nettype none
module rst_irq_ctrl (
  // Clock and power-on reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reset sources.
  input wire logic ext_reset_pin,
  input wire logic dog_reset_evt,
  // Interrupt pins and peripheral events.
  input wire logic [5:0] ext_irq_pin,
  input wire rst_irq_pkg::periph_evt_s periph_evt,
  // Core side.
  input wire rst_irq_pkg::irq_ack_s irq_ack,
  input wire rst_irq_pkg::core_wr_s core_wr,
  output logic core_reset,
  output logic [11:0] irq_req,
  output logic power_fail_req,
  output logic [15:0] program_counter,
  output logic [7:0] stack_pointer,
  output logic [3:0][7:0] port_out,
  output logic [1:0] tmr_run,
  output logic dog_reset_enable
);
  import rst_irq_pkg::*;

  logic [31:0] addr_r;
  logic wr_pend_r;
  logic rd_wait_r;
  logic [7:0] irq_enable_r;
  logic [7:0] irq_level_r;
  logic [7:0] tmr2_mode_r;
  logic [7:0] tmr_control_r;
  logic [7:0] dog_control_r;
  logic [7:0] ext_irq_enable_r;
  logic [7:0] uart0_control_r;
  logic [7:0] ext_irq_level_r;
  logic [7:0] uart1_control_r;
  logic [7:0] ext_irq_flag_r;
  logic [7:0] tmr2_status_r;
  logic [7:0] tmr_control_nxt;
  logic [7:0] dog_control_nxt;
  logic [7:0] ext_irq_flag_nxt;
  logic [7:0] tmr2_status_nxt;
  logic [7:0] uart0_control_nxt;
  logic [7:0] uart1_control_nxt;
  logic [1:0] mc_cnt_r;
  logic mc_en_r;
  logic [1:0] rst_cnt_r;
  logic soft_rst;
  logic [5:0] pin_samp_r;
  logic [5:0] pin_fall;
  logic [11:0] src_raw;
  logic [11:0] src_en;
  logic [7:0] ram_rd_data;
  logic [7:0] rd_mux;
  logic addr_take;
  logic wr_stb;
  logic ram_hit;
  logic ack_ext0;
  logic ack_ext1;

  assign addr_take = hsel && hready && htrans[1];
  assign wr_stb = wr_pend_r;
  assign ram_hit = addr_r[31:10] == RAM_BASE_TAG;
  assign ack_ext0 = irq_ack.valid && irq_ack.src == SRC_EXT0;
  assign ack_ext1 = irq_ack.valid && irq_ack.src == SRC_EXT1;

  function automatic logic wsel(input logic [31:0] a, input logic [31:0] off,
                                input logic stb);
    wsel = stb && a == off;
  endfunction : wsel

  // Bus slave: writes finish with no wait, reads take one wait state so
  // that read data leave a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      rd_wait_r <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rd_wait_r) begin
        rd_wait_r <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= {24'h00_0000, rd_mux};
      end else begin
        wr_pend_r <= addr_take && hwrite;
        if (addr_take) begin
          addr_r <= haddr;
          rd_wait_r <= !hwrite;
          hreadyout <= hwrite;
        end
      end
    end
  end

  data_ram u_data_ram (
    .clk(hclk),
    .wr_en(wr_stb && ram_hit),
    .wr_addr(addr_r[9:2]),
    .wr_data(hwdata[7:0]),
    .rd_addr(haddr[9:2]),
    .rd_data(ram_rd_data)
  );

  // Machine-cycle enable from the clock divider.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mc_cnt_r <= 2'h0;
      mc_en_r <= 1'b0;
    end else begin
      mc_en_r <= mc_cnt_r == MC_LAST;
      mc_cnt_r <= (mc_cnt_r == MC_LAST) ? 2'h0 : mc_cnt_r + 2'h1;
    end
  end

  // Internal reset: held while the pin is high and two machine cycles
  // beyond, or for two machine cycles after a watchdog reset.
  assign soft_rst = ext_reset_pin || dog_reset_evt || rst_cnt_r != 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_cnt_r <= 2'h0;
      core_reset <= 1'b1;
    end else begin
      core_reset <= soft_rst;
      if (ext_reset_pin || dog_reset_evt) begin
        rst_cnt_r <= RST_HOLD_MC;
      end else if (mc_en_r && rst_cnt_r != 2'h0) begin
        rst_cnt_r <= rst_cnt_r - 2'h1;
      end
    end
  end

  // Core state registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_counter <= RST_PROG_COUNTER;
      stack_pointer <= RST_STACK_POINTER;
    end else if (soft_rst) begin
      program_counter <= RST_PROG_COUNTER;
      stack_pointer <= RST_STACK_POINTER;
    end else begin
      if (core_wr.counter_wr) begin
        program_counter <= core_wr.counter_wdata;
      end
      if (core_wr.stack_wr) begin
        stack_pointer <= core_wr.stack_wdata;
      end
    end
  end

  generate
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          port_out[p] <= RST_PORT;
        end else if (soft_rst) begin
          port_out[p] <= RST_PORT;
        end else if (wsel(addr_r, OFF_PORT_BASE + 32'(4 * p), wr_stb)) begin
          port_out[p] <= hwdata[7:0];
        end
      end
    end
  endgenerate

  // Pins are sampled once per machine cycle; a high sample then a low
  // one is a falling edge. Narrower pulses are missed unless they span a sample.
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      assign pin_fall[i] = mc_en_r && pin_samp_r[i] && !ext_irq_pin[i];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pin_samp_r[i] <= 1'b1;
        end else if (mc_en_r) begin
          pin_samp_r[i] <= ext_irq_pin[i];
        end
      end
    end
  endgenerate

  // Plain control registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_enable_r <= RST_ZERO;
      ext_irq_enable_r <= RST_ZERO;
      irq_level_r <= RST_ZERO;
      ext_irq_level_r <= RST_ZERO;
      tmr2_mode_r <= RST_ZERO;
    end else if (soft_rst) begin
      irq_enable_r <= RST_ZERO;
      ext_irq_enable_r <= RST_ZERO;
      irq_level_r <= RST_ZERO;
      ext_irq_level_r <= RST_ZERO;
      tmr2_mode_r <= RST_ZERO;
    end else begin
      if (wsel(addr_r, OFF_IRQ_ENABLE, wr_stb)) begin
        irq_enable_r <= hwdata[7:0];
      end
      if (wsel(addr_r, OFF_EXT_IRQ_ENABLE, wr_stb)) begin
        ext_irq_enable_r <= hwdata[7:0] & EXT_MASK;
      end
      if (wsel(addr_r, OFF_IRQ_LEVEL, wr_stb)) begin
        irq_level_r <= hwdata[7:0] & LEVEL_MASK;
      end
      if (wsel(addr_r, OFF_EXT_IRQ_LEVEL, wr_stb)) begin
        ext_irq_level_r <= hwdata[7:0] & EXT_MASK;
      end
      if (wsel(addr_r, OFF_TMR2_MODE, wr_stb)) begin
        tmr2_mode_r <= hwdata[7:0];
      end
    end
  end

  // Flag next values: software write first, then acknowledge clears,
  // then hardware sets, so an event never loses to a clear.
  always_comb begin
    tmr_control_nxt = tmr_control_r;
    if (wsel(addr_r, OFF_TMR_CONTROL, wr_stb)) begin
      tmr_control_nxt = hwdata[7:0];
    end
    if (ack_ext0 && tmr_control_r[TC_SENSE0]) begin
      tmr_control_nxt[TC_FLAG0] = 1'b0;
    end
    if (ack_ext1 && tmr_control_r[TC_SENSE1]) begin
      tmr_control_nxt[TC_FLAG1] = 1'b0;
    end
    if (irq_ack.valid && irq_ack.src == SRC_TMR0) begin
      tmr_control_nxt[TC_OVF0] = 1'b0;
    end
    if (irq_ack.valid && irq_ack.src == SRC_TMR1) begin
      tmr_control_nxt[TC_OVF1] = 1'b0;
    end
    if (periph_evt.tmr0_ovf) begin
      tmr_control_nxt[TC_OVF0] = 1'b1;
    end
    if (periph_evt.tmr1_ovf) begin
      tmr_control_nxt[TC_OVF1] = 1'b1;
    end
    // Level mode tracks the pin each machine cycle and ignores service
    // entry, so a pin still low after the routine asks again.
    if (tmr_control_r[TC_SENSE0]) begin
      if (pin_fall[0]) begin
        tmr_control_nxt[TC_FLAG0] = 1'b1;
      end
    end else if (mc_en_r) begin
      tmr_control_nxt[TC_FLAG0] = !ext_irq_pin[0];
    end
    if (tmr_control_r[TC_SENSE1]) begin
      if (pin_fall[1]) begin
        tmr_control_nxt[TC_FLAG1] = 1'b1;
      end
    end else if (mc_en_r) begin
      tmr_control_nxt[TC_FLAG1] = !ext_irq_pin[1];
    end
  end

  always_comb begin
    ext_irq_flag_nxt = ext_irq_flag_r;
    if (wsel(addr_r, OFF_EXT_IRQ_FLAG, wr_stb)) begin
      ext_irq_flag_nxt = hwdata[7:0] & 8'hF0;
    end
    for (int k = 0; k < 4; k++) begin
      if (irq_ack.valid && irq_ack.src == SRC_EXT2 + 4'(k) &&
          tmr2_mode_r[XF_FLAG2 + k]) begin
        ext_irq_flag_nxt[XF_FLAG2 + k] = 1'b0;
      end
      if (pin_fall[2 + k]) begin
        ext_irq_flag_nxt[XF_FLAG2 + k] = 1'b1;
      end
    end
  end

  always_comb begin
    tmr2_status_nxt = tmr2_status_r;
    uart0_control_nxt = uart0_control_r;
    uart1_control_nxt = uart1_control_r;
    if (wsel(addr_r, OFF_TMR2_STATUS, wr_stb)) begin
      tmr2_status_nxt = hwdata[7:0];
    end
    if (wsel(addr_r, OFF_UART0_CONTROL, wr_stb)) begin
      uart0_control_nxt = hwdata[7:0];
    end
    if (wsel(addr_r, OFF_UART1_CONTROL, wr_stb)) begin
      uart1_control_nxt = hwdata[7:0];
    end
    tmr2_status_nxt[T2_OVF] = tmr2_status_nxt[T2_OVF] || periph_evt.tmr2_ovf;
    tmr2_status_nxt[T2_CAP] = tmr2_status_nxt[T2_CAP] || periph_evt.tmr2_cap;
    uart0_control_nxt[UC_RX_DONE] =
      uart0_control_nxt[UC_RX_DONE] || periph_evt.rx0_done;
    uart0_control_nxt[UC_TX_DONE] =
      uart0_control_nxt[UC_TX_DONE] || periph_evt.tx0_done;
    uart1_control_nxt[UC_RX_DONE] =
      uart1_control_nxt[UC_RX_DONE] || periph_evt.rx1_done;
    uart1_control_nxt[UC_TX_DONE] =
      uart1_control_nxt[UC_TX_DONE] || periph_evt.tx1_done;
  end

  // Watchdog control: the reset image depends on what caused the reset.
  always_comb begin
    dog_control_nxt = dog_control_r;
    if (soft_rst) begin
      dog_control_nxt = dog_control_r & DOG_KEEP_MASK;
      if (dog_reset_evt) begin
        dog_control_nxt = dog_control_nxt | DOG_DOG_RESET_FLAG_SET;
      end
    end else if (wsel(addr_r, OFF_DOG_CONTROL, wr_stb)) begin
      dog_control_nxt = hwdata[7:0];
      dog_control_nxt[DG_POWER_ON] =
        dog_control_r[DG_POWER_ON] && hwdata[DG_POWER_ON];
    end
    if (periph_evt.power_fail) begin
      dog_control_nxt[DG_POWER_FAIL] = 1'b1;
    end
    if (periph_evt.dog_expiry && !soft_rst) begin
      dog_control_nxt[DG_EXPIRY] = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dog_control_r <= RST_DOG_POWER_ON;
    end else begin
      dog_control_r <= dog_control_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_control_r <= RST_ZERO;
      ext_irq_flag_r <= RST_ZERO;
      tmr2_status_r <= RST_ZERO;
      uart0_control_r <= RST_ZERO;
      uart1_control_r <= RST_ZERO;
    end else if (soft_rst) begin
      tmr_control_r <= RST_ZERO;
      ext_irq_flag_r <= RST_ZERO;
      tmr2_status_r <= RST_ZERO;
      uart0_control_r <= RST_ZERO;
      uart1_control_r <= RST_ZERO;
    end else begin
      tmr_control_r <= tmr_control_nxt;
      ext_irq_flag_r <= ext_irq_flag_nxt;
      tmr2_status_r <= tmr2_status_nxt;
      uart0_control_r <= uart0_control_nxt;
      uart1_control_r <= uart1_control_nxt;
    end
  end

  // Request gathering in priority order, gated by enables.
  assign src_raw = {dog_control_r[DG_EXPIRY],
                    ext_irq_flag_r[7:4],
                    uart1_control_r[UC_RX_DONE] || uart1_control_r[UC_TX_DONE],
                    tmr2_status_r[T2_OVF] || tmr2_status_r[T2_CAP],
                    uart0_control_r[UC_RX_DONE] || uart0_control_r[UC_TX_DONE],
                    tmr_control_r[TC_OVF1],
                    tmr_control_r[TC_FLAG1],
                    tmr_control_r[TC_OVF0],
                    tmr_control_r[TC_FLAG0]};
  assign src_en = {ext_irq_enable_r[EN_DOG],
                   ext_irq_enable_r[3:0],
                   irq_enable_r[EN_UART1],
                   irq_enable_r[EN_TMR2],
                   irq_enable_r[EN_UART0],
                   irq_enable_r[EN_TMR1],
                   irq_enable_r[EN_EXT1],
                   irq_enable_r[EN_TMR0],
                   irq_enable_r[EN_EXT0]};

  // Power-fail bypasses the global gate so software still hears of it
  // with interrupts switched off.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 12'h000;
      power_fail_req <= 1'b0;
      tmr_run <= 2'h0;
      dog_reset_enable <= 1'b0;
    end else begin
      irq_req <= src_raw & src_en & {NUM_SRC{irq_enable_r[EN_GLOBAL]}};
      power_fail_req <= dog_control_r[DG_POWER_FAIL] &&
                        dog_control_r[DG_PF_ENABLE];
      tmr_run <= {tmr_control_r[6], tmr_control_r[4]};
      dog_reset_enable <= dog_control_r[DG_RESET_EN];
    end
  end

  // Register read mux; unmapped addresses read zero.
  always_comb begin
    rd_mux = 8'h00;
    if (ram_hit) begin
      rd_mux = ram_rd_data;
    end else begin
      unique case (addr_r)
        OFF_IRQ_ENABLE: rd_mux = irq_enable_r;
        OFF_IRQ_LEVEL: rd_mux = irq_level_r;
        OFF_TMR2_MODE: rd_mux = tmr2_mode_r;
        OFF_TMR_CONTROL: rd_mux = tmr_control_r;
        OFF_DOG_CONTROL: rd_mux = dog_control_r;
        OFF_EXT_IRQ_ENABLE: rd_mux = ext_irq_enable_r;
        OFF_UART0_CONTROL: rd_mux = uart0_control_r;
        OFF_EXT_IRQ_LEVEL: rd_mux = ext_irq_level_r;
        OFF_UART1_CONTROL: rd_mux = uart1_control_r;
        OFF_EXT_IRQ_FLAG: rd_mux = ext_irq_flag_r;
        OFF_TMR2_STATUS: rd_mux = tmr2_status_r;
        OFF_STACK_POINTER: rd_mux = stack_pointer;
        OFF_PROG_COUNTER: rd_mux = program_counter[7:0];
        OFF_PORT_BASE: rd_mux = port_out[0];
        OFF_PORT_BASE + 32'h4: rd_mux = port_out[1];
        OFF_PORT_BASE + 32'h8: rd_mux = port_out[2];
        OFF_PORT_BASE + 32'hC: rd_mux = port_out[3];
        default: rd_mux = 8'h00;
      endcase
    end
  end
endmodule : rst_irq_ctrl
`default_nettype wire

// ---- tb/rst_irq_far_end.sv ----
// Model of the interrupt pins and the core's acknowledge strobe.
// Assumes the bench commands pin levels and acknowledges each cycle.
`default_nettype none
module rst_irq_far_end (
  // Clock.
  input wire logic hclk,
  // Bench commands.
  input wire logic [5:0] pin_cmd,
  input wire rst_irq_pkg::irq_ack_s ack_cmd,
  // Pins and acknowledge.
  output logic [5:0] ext_irq_pin,
  output rst_irq_pkg::irq_ack_s irq_ack
);
  import rst_irq_pkg::*;
  int held = 0;
  initial ext_irq_pin = 6'h3F;
  initial irq_ack = '0;
  // A level shorter than one machine cycle may miss a sample.
  always @(posedge hclk) begin
    held <= held + 1;
    if (pin_cmd != ext_irq_pin && held >= 2 * MC_CLOCKS) begin
      ext_irq_pin <= pin_cmd;
      held <= 0;
    end
  end
  always @(posedge hclk) irq_ack <= ack_cmd;
endmodule : rst_irq_far_end
`default_nettype wire

// ---- tb/rst_irq_ctrl_asserts.sv ----
// Port checker for the reset-state and interrupt-source block.
// Assumes it is bound to rst_irq_ctrl and sees only its ports.
`default_nettype none
module rst_irq_ctrl_asserts (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Bus.
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  // Core side.
  input wire rst_irq_pkg::irq_ack_s irq_ack,
  input wire rst_irq_pkg::periph_evt_s periph_evt,
  input wire logic core_reset,
  input wire logic [11:0] irq_req,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] stack_pointer,
  input wire logic [3:0][7:0] port_out,
  input wire logic [1:0] tmr_run
);
  import rst_irq_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence ack_tmr0;
    irq_ack.valid && irq_ack.src == SRC_TMR0 && !periph_evt.tmr0_ovf
      ##1 !periph_evt.tmr0_ovf;
  endsequence
  sequence ack_tmr2;
    irq_ack.valid && irq_ack.src == 4'h5 && irq_req[5] && !htrans[1];
  endsequence
  pc_held_a: assert property (
    core_reset |-> program_counter == 16'h0000)
    else $error("counter not held in reset");
  sp_reset_a: assert property (
    core_reset |-> stack_pointer == 8'h07)
    else $error("stack not 07 in reset");
  port_reset_a: assert property (
    core_reset |-> port_out == {4{8'hFF}})
    else $error("ports not high in reset");
  // The gated outputs copy their registers one cycle late, so they are
  // only known to be clear from the second cycle of a reset on.
  irq_off_a: assert property (
    core_reset && $past(core_reset) |-> irq_req == 12'h000)
    else $error("request during reset");
  tmr_off_a: assert property (
    core_reset && $past(core_reset) |-> tmr_run == 2'h0)
    else $error("timer runs during reset");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite
    |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
  tmr0_clear_a: assert property (ack_tmr0 |=> !irq_req[1])
    else $error("timer 0 flag kept");
  tmr2_keep_a: assert property (ack_tmr2 |=> irq_req[5] [*2])
    else $error("timer 2 flag cleared");
endmodule : rst_irq_ctrl_asserts
bind rst_irq_ctrl rst_irq_ctrl_asserts u_chk (.hclk, .hresetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .irq_ack, .periph_evt,
  .core_reset, .irq_req, .program_counter, .stack_pointer, .port_out,
  .tmr_run);
`default_nettype wire

// ---- tb/test_rst_irq_ctrl.sv ----
// Self-checking bench for the reset-state and interrupt-source block.
// Assumes this bench is the only AHB-Lite master.
`default_nettype none
module test_rst_irq_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import rst_irq_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0, tmr_run;
  logic ext_reset_pin = 1'b0, dog_reset_evt = 1'b0;
  periph_evt_s periph_evt = '0;
  irq_ack_s ack_cmd = '0, irq_ack;
  logic [5:0] pin_cmd = 6'h3F, ext_irq_pin;
  logic hreadyout, hresp, core_reset, power_fail_req, dog_reset_enable;
  logic [11:0] irq_req;
  logic [15:0] program_counter;
  logic [7:0] stack_pointer;
  logic [3:0][7:0] port_out;
  int miscompares = 0;
  int tests_run = 0;
  always #2.5 hclk = ~hclk;
  rst_irq_ctrl i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .ext_reset_pin, .dog_reset_evt, .ext_irq_pin, .periph_evt, .irq_ack,
    .core_wr('0), .core_reset, .irq_req, .power_fail_req, .program_counter,
    .stack_pointer, .port_out, .tmr_run, .dog_reset_enable);
  rst_irq_far_end i_far (.hclk, .pin_cmd, .ack_cmd, .ext_irq_pin, .irq_ack);
  task automatic results;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task automatic wait_ready;
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    miscompares++;
    results();
  endtask : wait_ready
  // Reads always see one wait state, but the master never counts on it.
  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rdc(input logic [31:0] a, exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rdc
  task automatic evt(input logic [9:0] e);
    periph_evt <= periph_evt_s'(e);
    @(posedge hclk);
    periph_evt <= '0;
    cyc(3);
  endtask : evt
  task automatic ack(input logic [3:0] s);
    ack_cmd <= '{1'b1, s};
    @(posedge hclk);
    ack_cmd <= '0;
    cyc(4);
  endtask : ack
  task automatic t_reset;
    rdc(OFF_DOG_CONTROL, 32'h40);
    rdc(OFF_STACK_POINTER, 32'h07);
    rdc(OFF_PROG_COUNTER, 32'h00);
    rdc(OFF_PORT_BASE + 32'hC, 32'hFF);
    rdc(OFF_IRQ_ENABLE, 32'h00);
  endtask : t_reset
  // Power-fail is enabled here with the global gate still shut.
  task automatic t_sources_reset;
    wr(32'h400, 32'hA5);
    wr(OFF_DOG_CONTROL, 32'h62);
    wr(OFF_TMR_CONTROL, 32'h50);
    evt(10'h001);
    rdc(OFF_DOG_CONTROL, 32'h72);
    chk(32'(power_fail_req), 32'h1);
    ext_reset_pin <= 1'b1;
    cyc(8);
    ext_reset_pin <= 1'b0;
    cyc(16);
    rdc(OFF_TMR_CONTROL, 32'h00);
    rdc(OFF_DOG_CONTROL, 32'h52);
    chk(32'(dog_reset_enable), 32'h1);
    dog_reset_evt <= 1'b1;
    cyc(1);
    dog_reset_evt <= 1'b0;
    cyc(16);
    rdc(OFF_DOG_CONTROL, 32'h56);
    hresetn <= 1'b0;
    cyc(4);
    hresetn <= 1'b1;
    rdc(OFF_DOG_CONTROL, 32'h40);
    rdc(32'h400, 32'hA5);
    chk(32'(dog_reset_enable), 32'h0);
  endtask : t_sources_reset
  task automatic t_timers;
    wr(OFF_IRQ_ENABLE, 32'h82);
    evt(10'h200);
    chk(32'(irq_req), 32'h002);
    ack(SRC_TMR0);
    chk(32'(irq_req), 32'h000);
    wr(OFF_IRQ_ENABLE, 32'h02);
    evt(10'h200);
    chk(32'(irq_req), 32'h000);
    rdc(OFF_TMR_CONTROL, 32'h20);
    wr(OFF_IRQ_ENABLE, 32'hF0);
    evt(10'h060);
    ack(4'h5);
    ack(4'h4);
    chk(32'(irq_req), 32'h030);
    wr(OFF_TMR2_STATUS, 32'h00);
    wr(OFF_UART0_CONTROL, 32'h00);
    wr(OFF_UART1_CONTROL, 32'h01);
    cyc(3);
    chk(32'(irq_req), 32'h040);
    wr(OFF_UART1_CONTROL, 32'h00);
    wr(OFF_EXT_IRQ_ENABLE, 32'h10);
    evt(10'h002);
    chk(32'(irq_req), 32'h800);
    rdc(OFF_DOG_CONTROL, 32'h48);
  endtask : t_timers
  task automatic t_pins;
    wr(OFF_TMR_CONTROL, 32'h01);
    wr(OFF_IRQ_ENABLE, 32'h81);
    wr(OFF_EXT_IRQ_ENABLE, 32'h01);
    wr(OFF_TMR2_MODE, 32'h10);
    pin_cmd <= 6'h3A;
    cyc(12);
    chk(32'(irq_req), 32'h081);
    ack(SRC_EXT0);
    ack(SRC_EXT2);
    chk(32'(irq_req), 32'h000);
    pin_cmd <= 6'h3F;
    wr(OFF_TMR_CONTROL, 32'h00);
    cyc(12);
    pin_cmd <= 6'h3E;
    cyc(12);
    ack(SRC_EXT0);
    chk(32'(irq_req), 32'h001);
    pin_cmd <= 6'h3F;
    cyc(12);
    chk(32'(irq_req), 32'h000);
  endtask : t_pins
  initial begin
    cyc(4);
    hresetn <= 1'b1;
    t_reset();
    t_sources_reset();
    t_timers();
    t_pins();
    results();
  end
endmodule : test_rst_irq_ctrl
`default_nettype wire
